//--- tpl_cmd.sv
// command handler for load/unload, locate, log select and log sense
`timescale 1ns/100ps
module tpl_cmd (
    input  wire logic                        core_clk,
    input  wire logic                        reset,
    input  wire logic [tpl_pkg::ADDR_W-1:0]  addr,
    input  wire logic [31:0]                 wdata,
    input  wire logic                        wr,
    input  wire logic                        rd,
    output logic      [31:0]                 rdata,
    input  wire logic                        cartridge_present,
    input  wire logic                        manual_load,
    input  wire logic [tpl_pkg::NUM_CNT-1:0] cnt_inc,
    output logic                             mech_req,
    output tpl_pkg::tpl_mop_t                mech_op,
    output logic      [31:0]                 mech_block,
    output logic      [7:0]                  mech_part,
    output logic                             mech_readahead,
    input  wire logic                        mech_done,
    output logic                             seek_complete_flag,
    output logic                             not_ready
);
    import tpl_pkg::*;

    logic [7:0]  pkt [PKT_BYTES];
    tpl_state_t  state;
    logic        loaded;
    logic        cur_unload;
    logic        has_step2;
    tpl_mop_t    step2_op;
    logic        step2_ra;
    logic [7:0]  partition;
    logic [31:0] position;
    logic        err_nr;
    logic        err_ill;
    logic [15:0] sel_left;
    logic [6:0]  sense_n;
    logic [6:0]  sense_left;
    logic [6:0]  sense_skip;
    logic [5:0]  sense_page;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // packet bytes, little end of each word is the lower byte
    for (genvar w = 0; w < 3; w++) begin : gen_pkt_w
        for (genvar b = 0; b < 4; b++) begin : gen_pkt_b
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    pkt[4*w+b] <= 8'h00;
                end else if (wr && addr == OFF_PKT0 + 6'(4*w)) begin
                    pkt[4*w+b] <= wdata[8*b +: 8];
                end
            end
        end
    end

    wire logic [7:0]  f_op     = pkt[0];
    wire logic        f_load   = pkt[4][LOAD_POS];
    wire logic        f_reten  = pkt[4][RETEN_POS];
    wire logic        f_endsel = pkt[4][END_SEL_POS];
    wire logic        f_cp     = pkt[1][CP_POS];
    wire logic        f_pcr    = pkt[1][PCR_POS];
    wire logic [1:0]  f_pc     = pkt[2][7:6];
    wire logic [5:0]  f_page   = pkt[2][5:0];
    wire logic [31:0] f_lba    = {pkt[3], pkt[4], pkt[5], pkt[6]};
    wire logic [7:0]  f_partno = pkt[8];
    wire logic [15:0] f_ptr    = {pkt[5], pkt[6]};
    wire logic [15:0] f_len    = {pkt[7], pkt[8]};

    // number of error-page parameters whose code lies below the pointer
    function automatic logic [2:0] first_param(input logic [15:0] ptr);
        logic [2:0] k;
        k = 3'h0;
        for (int i = 0; i < NUM_CNT; i++) begin
            if (ERR_CODES[i] < ptr) begin
                k = k + 3'h1;
            end
        end
        return k;
    endfunction : first_param

    function automatic logic [7:0] param_byte(input logic [2:0]  off,
                                              input logic [15:0] code,
                                              input logic [31:0] val);
        case (off)
            3'h0:    return code[15:8];
            3'h1:    return code[7:0];
            3'h2:    return PARAM_BITS;
            3'h3:    return PARAM_LEN;
            3'h4:    return val[31:24];
            3'h5:    return val[23:16];
            3'h6:    return val[15:8];
            default: return val[7:0];
        endcase
    endfunction : param_byte

    wire logic go        = wr && addr == OFF_GO && state == S_IDLE;
    wire logic is_load   = f_op == OP_LOAD && f_load;
    wire logic is_unload = f_op == OP_LOAD && !f_load;
    wire logic is_locate = f_op == OP_LOCATE;
    wire logic is_lsel   = f_op == OP_LOG_SEL;
    wire logic is_lsense = f_op == OP_LOG_SENSE;
    wire logic page_ok   = f_page == PAGE_SUPPORTED || f_page == PAGE_READ_ERR;
    wire logic pc_ok     = f_pc == PC_CURRENT;

    wire logic acc_load   = go && is_load && cartridge_present;
    wire logic acc_unload = go && is_unload && loaded;
    wire logic acc_locate = go && is_locate && loaded;
    wire logic acc_lsel   = go && is_lsel && pc_ok;
    wire logic acc_lsense = go && is_lsense && pc_ok && page_ok;
    wire logic rej_nr     = go && ((is_load && !cartridge_present) ||
                                   ((is_unload || is_locate) && !loaded));
    wire logic accepted   = acc_load || acc_unload || acc_locate || acc_lsel || acc_lsense;
    wire logic rej_ill    = go && !accepted && !rej_nr;
    wire logic cnt_clear  = acc_lsel && f_pcr && f_len == 16'h0000;

    // log sense sizing: header always sent, parameters start at the pointer
    wire logic [2:0] k_start = first_param(f_ptr);
    wire logic [6:0] skip    = (f_page == PAGE_READ_ERR) ? 7'({k_start, 3'h0}) : 7'h00;
    wire logic [6:0] avail   = (f_page == PAGE_READ_ERR) ? ERR_TOTAL - skip : SUP_TOTAL;
    wire logic [6:0] lim     = (f_len < 16'(avail)) ? f_len[6:0] : avail;

    // error counters; reset, a clearing log select, or an increment past all ones (wrap) zero them
    wire logic [32*NUM_CNT-1:0] cnt_all;
    for (genvar g = 0; g < NUM_CNT; g++) begin : gen_cnt
        logic [31:0] value;
        always_ff @(posedge core_clk) begin
            if (reset || cnt_clear) begin
                value <= 32'h0;
            end else if (cnt_inc[g]) begin
                value <= value + 32'h1;
            end
        end
        assign cnt_all[32*g +: 32] = value;
    end

    // byte currently offered on the data-out port
    wire logic [6:0]  idx     = (sense_n < HDR_BYTES) ? sense_n : sense_n + sense_skip;
    wire logic [6:0]  rel     = idx - HDR_BYTES;
    wire logic [2:0]  pnum    = rel[5:3];
    wire logic        pnum_ok = 32'(pnum) < NUM_CNT;
    wire logic [31:0] cnt_sel = pnum_ok ? cnt_all[32*pnum +: 32] : 32'h0;
    wire logic [15:0] code    = pnum_ok ? ERR_CODES[pnum] : 16'h0000;
    wire logic [7:0]  sup_b   = SUP_PAGE[idx[2:0]];
    wire logic [7:0]  err_b   = (idx < HDR_BYTES) ? ERR_HDR[idx[1:0]]
                              : param_byte(rel[2:0], code, cnt_sel);
    wire logic        dvalid  = state == S_SENSE;
    wire logic [7:0]  cur_b   = !dvalid ? 8'h00
                              : (sense_page == PAGE_READ_ERR) ? err_b : sup_b;
    wire logic pop  = rd && addr == OFF_DATA_OUT && dvalid;
    wire logic push = wr && addr == OFF_DATA_IN && state == S_SELECT;

    // target motion of locate and unload, sent second after a partition change or retension
    wire logic     blk0    = f_lba == 32'h0;
    wire tpl_mop_t loc_op  = blk0 ? MOP_TO_START : MOP_LOCATE;
    wire tpl_mop_t end_op  = f_endsel ? MOP_TO_END : MOP_TO_START;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state              <= S_IDLE;
            seek_complete_flag <= RST_DSC;
            loaded             <= 1'b0;
            partition          <= RST_PART;
            position           <= 32'h0;
            cur_unload         <= 1'b0;
            has_step2          <= 1'b0;
            step2_op           <= MOP_REWIND;
            step2_ra           <= 1'b0;
            mech_req           <= 1'b0;
            mech_op            <= MOP_REWIND;
            mech_block         <= 32'h0;
            mech_part          <= RST_PART;
            mech_readahead     <= 1'b0;
            err_nr             <= 1'b0;
            err_ill            <= 1'b0;
            sel_left           <= 16'h0;
            sense_n            <= 7'h0;
            sense_left         <= 7'h0;
            sense_skip         <= 7'h0;
            sense_page         <= PAGE_SUPPORTED;
        end else begin
            mech_req <= 1'b0;
            if (go) begin
                err_nr  <= rej_nr;
                err_ill <= rej_ill;
            end
            case (state)
                S_IDLE: begin
                    if (acc_load) begin
                        seek_complete_flag <= 1'b0;
                        partition          <= RST_PART;
                        cur_unload         <= 1'b0;
                        mech_req           <= 1'b1;
                        mech_op            <= f_reten ? MOP_RETENSION : MOP_REWIND;
                        mech_part          <= RST_PART;
                        mech_block         <= 32'h0;
                        mech_readahead     <= 1'b0;
                        has_step2          <= f_reten;
                        step2_op           <= MOP_REWIND;
                        step2_ra           <= 1'b0;
                        state              <= S_STEP1;
                    end else if (acc_unload) begin
                        seek_complete_flag <= 1'b0;
                        cur_unload         <= 1'b1;
                        mech_req           <= 1'b1;
                        mech_op            <= f_reten ? MOP_RETENSION : end_op;
                        mech_readahead     <= 1'b0;
                        has_step2          <= f_reten;
                        step2_op           <= end_op;
                        step2_ra           <= 1'b0;
                        state              <= S_STEP1;
                    end else if (acc_locate) begin
                        seek_complete_flag <= 1'b0;
                        cur_unload         <= 1'b0;
                        mech_req           <= 1'b1;
                        mech_block         <= f_lba;
                        mech_op            <= f_cp ? MOP_PARTITION : loc_op;
                        mech_readahead     <= !f_cp && !blk0;
                        mech_part          <= f_cp ? f_partno : partition;
                        if (f_cp) begin
                            partition <= f_partno;
                        end
                        has_step2          <= f_cp;
                        step2_op           <= loc_op;
                        step2_ra           <= !blk0;
                        state              <= S_STEP1;
                    end else if (acc_lsel && f_len != 16'h0000) begin
                        sel_left <= f_len;
                        state    <= S_SELECT;
                    end else if (acc_lsense && lim != 7'h0) begin
                        sense_n    <= 7'h0;
                        sense_left <= lim;
                        sense_skip <= skip;
                        sense_page <= f_page;
                        state      <= S_SENSE;
                    end else if (manual_load && cartridge_present) begin
                        loaded    <= 1'b1;
                        partition <= RST_PART;
                        position  <= 32'h0;
                    end
                end
                S_STEP1: begin
                    if (mech_done && has_step2) begin
                        mech_req       <= 1'b1;
                        mech_op        <= step2_op;
                        mech_readahead <= step2_ra;
                        state          <= S_STEP2;
                    end else if (mech_done) begin
                        seek_complete_flag <= 1'b1;
                        loaded             <= !cur_unload;
                        position           <= mech_op == MOP_LOCATE ? mech_block : 32'h0;
                        state              <= S_IDLE;
                    end
                end
                S_STEP2: begin
                    if (mech_done) begin
                        seek_complete_flag <= 1'b1;
                        loaded             <= !cur_unload;
                        position           <= mech_op == MOP_LOCATE ? mech_block : 32'h0;
                        state              <= S_IDLE;
                    end
                end
                S_SENSE: begin
                    if (pop) begin
                        sense_n    <= sense_n + 7'h1;
                        sense_left <= sense_left - 7'h1;
                        if (sense_left == 7'h1) begin
                            state <= S_IDLE;
                        end
                    end
                end
                S_SELECT: begin
                    if (push) begin
                        sel_left <= sel_left - 16'h1;
                        if (sel_left == 16'h1) begin
                            state <= S_IDLE;
                        end
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    assign not_ready = !loaded;

    wire logic [31:0] status_word = {16'h0, partition, 1'b0, dvalid, err_ill, err_nr,
                                     cartridge_present, state != S_IDLE, loaded,
                                     seek_complete_flag};
    wire logic [15:0] left_word   = (state == S_SELECT) ? sel_left : 16'(sense_left);
    wire logic [31:0] read_mux    =
        (addr == OFF_PKT0)     ? {pkt[3], pkt[2], pkt[1], pkt[0]}   :
        (addr == OFF_PKT1)     ? {pkt[7], pkt[6], pkt[5], pkt[4]}   :
        (addr == OFF_PKT2)     ? {pkt[11], pkt[10], pkt[9], pkt[8]} :
        (addr == OFF_STATUS)   ? status_word                        :
        (addr == OFF_DATA_OUT) ? {23'h0, dvalid, cur_b}             :
        (addr == OFF_POSITION) ? position                           :
        (addr == OFF_COUNT)    ? {16'h0, left_word}                 : 32'h0;

    // read data stand for exactly the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata <= 32'h0;
        end else begin
            rdata <= rd ? read_mux : 32'h0;
        end
    end

    load_any_a: assert property (go && is_load && cartridge_present |=>
        state == S_STEP1 && mech_req) else $error("load with cartridge not taken");
    load_part_a: assert property (acc_load |=> partition == 8'h00 &&
        (mech_op == MOP_REWIND || mech_op == MOP_RETENSION))
        else $error("load did not select partition zero");
    load_dsc_a: assert property (acc_load |=> !seek_complete_flag)
        else $error("load left seek flag set");
    unload_nr_a: assert property (state == S_STEP2 && cur_unload && mech_done |=>
        not_ready && seek_complete_flag) else $error("unload did not end not ready");
    nr_hold_a: assert property (not_ready && !manual_load &&
        (cur_unload || !(state == S_STEP1 || state == S_STEP2)) |=> not_ready)
        else $error("left not ready without a load");
    cp_first_a: assert property (acc_locate && f_cp |=>
        mech_op == MOP_PARTITION ##1 state == S_STEP1)
        else $error("partition change not done first");
    blk0_rewind_a: assert property (acc_locate && blk0 |=>
        (mech_op == MOP_TO_START || mech_op == MOP_PARTITION) && step2_op == MOP_TO_START &&
        !step2_ra && !mech_readahead) else $error("block zero read-ahead");
    locate_dsc_a: assert property (acc_locate |=> !seek_complete_flag
        throughout (state != S_IDLE)[*1]) else $error("locate left seek flag set");
    bad_pc_a: assert property (go && (is_lsel || is_lsense) && !pc_ok |=>
        err_ill && state == S_IDLE) else $error("wrong page control accepted");
    cnt_clr_a: assert property (cnt_clear |=>
        cnt_all == {(32*NUM_CNT){1'b0}}) else $error("counters not cleared");
    alloc_cap_a: assert property (acc_lsense && lim != 7'h0 |=>
        sense_left <= $past(f_len[6:0], 1) || $past(f_len, 1) > 16'h007f)
        else $error("sense exceeds allocation");
    sup_list_a: assert property (dvalid && sense_page == PAGE_SUPPORTED &&
        sense_n == 7'h6 |-> cur_b == 8'h31) else $error("supported list wrong");
    cnt_keep_a: assert property (!cnt_clear && cnt_all[31:0] != 32'h0 |=>
        cnt_all[31:0] != 32'h0) else $error("counter cleared without cause");
    sel_len_a: assert property (acc_lsel && f_len != 16'h0000 |=>
        state == S_SELECT && sel_left == $past(f_len))
        else $error("select length not taken");
    ptr_start_a: assert property (dvalid && sense_page == PAGE_READ_ERR &&
        sense_skip == 7'h20 && sense_n == 7'h4 |-> cur_b == 8'h80)
        else $error("pointer start wrong");
    err_len_a: assert property (dvalid && sense_page == PAGE_READ_ERR &&
        sense_n == 7'h3 |-> cur_b == 8'h30) else $error("error page length wrong");
    err_code_a: assert property (dvalid && sense_page == PAGE_READ_ERR &&
        sense_skip == 7'h00 && sense_n == 7'h15 |-> cur_b == 8'h20)
        else $error("track counter code wrong");
    locate_pos_a: assert property (mech_done && mech_op == MOP_LOCATE &&
        state == S_STEP2 |=> position == $past(mech_block))
        else $error("locate position not logical");
endmodule : tpl_cmd

//--- tpl_pkg.sv
// shared constants and types of the tape position and log command handler
package tpl_pkg;
    localparam int ADDR_W    = 6;
    localparam int PKT_BYTES = 12;
    localparam int NUM_CNT   = 6;

    localparam logic [5:0] OFF_PKT0     = 6'h00;
    localparam logic [5:0] OFF_PKT1     = 6'h04;
    localparam logic [5:0] OFF_PKT2     = 6'h08;
    localparam logic [5:0] OFF_GO       = 6'h0c;
    localparam logic [5:0] OFF_STATUS   = 6'h10;
    localparam logic [5:0] OFF_DATA_OUT = 6'h14;
    localparam logic [5:0] OFF_DATA_IN  = 6'h18;
    localparam logic [5:0] OFF_POSITION = 6'h1c;
    localparam logic [5:0] OFF_COUNT    = 6'h20;

    localparam logic [7:0] OP_LOAD      = 8'h1b;
    localparam logic [7:0] OP_LOCATE    = 8'h2b;
    localparam logic [7:0] OP_LOG_SEL   = 8'h4c;
    localparam logic [7:0] OP_LOG_SENSE = 8'h4d;

    localparam int LOAD_POS    = 0;
    localparam int RETEN_POS   = 1;
    localparam int END_SEL_POS = 2;
    localparam int CP_POS      = 1;
    localparam int PCR_POS     = 1;
    localparam logic [1:0] PC_CURRENT = 2'h1;

    localparam logic [5:0] PAGE_SUPPORTED = 6'h00;
    localparam logic [5:0] PAGE_READ_ERR  = 6'h03;
    localparam logic [7:0] PARAM_BITS     = 8'h40;
    localparam logic [7:0] PARAM_LEN      = 8'h04;
    localparam logic [6:0] HDR_BYTES      = 7'h04;
    localparam logic [6:0] SUP_TOTAL      = 7'h08;
    localparam logic [6:0] ERR_TOTAL      = 7'h34;
    localparam logic [7:0] SUP_PAGE [8] = '{8'h00, 8'h00, 8'h00, 8'h04,
                                            8'h00, 8'h03, 8'h31, 8'h00};
    localparam logic [7:0] ERR_HDR [4] = '{8'h03, 8'h00, 8'h00, 8'h30};
    localparam logic [15:0] ERR_CODES [NUM_CNT] = '{16'h0000, 16'h0001, 16'h8020,
                                                    16'h8021, 16'h8022, 16'h8023};

    localparam logic       RST_DSC  = 1'b1;
    localparam logic [7:0] RST_PART = 8'h00;

    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_STEP1  = 3'b001,
        S_STEP2  = 3'b011,
        S_SENSE  = 3'b010,
        S_SELECT = 3'b110
    } tpl_state_t;

    typedef enum logic [2:0] {
        MOP_REWIND    = 3'h0,
        MOP_RETENSION = 3'h1,
        MOP_TO_START  = 3'h2,
        MOP_TO_END    = 3'h3,
        MOP_PARTITION = 3'h4,
        MOP_LOCATE    = 3'h5
    } tpl_mop_t;
endpackage : tpl_pkg

//--- tpl_mech_model.sv
// behavioural tape mechanism answering each motion request after a set delay
`timescale 1ns/100ps
module tpl_mech_model (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       mech_req,
    input  wire logic [5:0] delay,
    output logic            mech_done
);
    logic [5:0] left;

    // delay is chosen by the bench so motions finish both promptly and slowly
    always_ff @(posedge core_clk) begin
        if (reset) begin
            left      <= 6'h00;
            mech_done <= 1'b0;
        end else begin
            mech_done <= (left == 6'h01);
            if (mech_req)
                left <= delay;
            else if (left != 6'h00)
                left <= left - 6'h01;
        end
    end
endmodule : tpl_mech_model

//--- tb_tape_position_log_commands.sv
// self-checking bench of the tape position and log command handler
`timescale 1ns/100ps
module tb_tape_position_log_commands;
    import tpl_pkg::*;
    logic        core_clk = 0, reset = 1, wr = 0, rd = 0, mload = 0, cart = 1;
    logic        done, seek, nrdy, req, ra, lra;
    logic [5:0]  addr = 0, inc = 0, dly = 6'h02;
    logic [31:0] wdata = 0, rdata, blk, lb, word;
    logic [7:0]  part, lp, pkt [12], eb [52];
    tpl_mop_t    op, ops [$];
    int          fail_count = 0, n_checks = 0, i;

    always #50 core_clk = ~core_clk;

    tpl_cmd dut (.core_clk, .reset, .addr, .wdata, .wr, .rd, .rdata, .cartridge_present(cart),
        .manual_load(mload), .cnt_inc(inc), .mech_req(req), .mech_op(op), .mech_block(blk),
        .mech_part(part), .mech_readahead(ra), .mech_done(done), .seek_complete_flag(seek),
        .not_ready(nrdy));
    tpl_mech_model mech (.core_clk, .reset, .mech_req(req), .delay(dly), .mech_done(done));

    always @(posedge core_clk) begin
        if (req) begin
            ops.push_back(op);
            lb = blk;
            lra = ra;
            lp = part;
        end
    end

    task automatic results;
        if (fail_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    task automatic chk(logic [31:0] g, logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic wrr(logic [5:0] a, logic [31:0] d);
        @(posedge core_clk);
        wr <= 1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk);
        wr <= 0;
    endtask : wrr

    // read data stand only in the cycle after the strobe
    task automatic rdr(logic [5:0] a);
        @(posedge core_clk);
        rd <= 1;
        addr <= a;
        @(posedge core_clk);
        rd <= 0;
        #1 word = rdata;
    endtask : rdr

    task automatic go;
        for (int w = 0; w < 3; w++)
            wrr(6'(4 * w), {pkt[4*w+3], pkt[4*w+2], pkt[4*w+1], pkt[4*w]});
        wrr(OFF_GO, 32'h0);
        #1;
    endtask : go

    task automatic idle;
        for (i = 0; i < 300; i++) begin
            rdr(OFF_STATUS);
            if (word[2] === 1'b0)
                return;
        end
        chk(32'h1, 32'h0);
        results();
    endtask : idle

    task automatic s_load(logic rt, logic [5:0] d);
        dly = d;
        ops = {};
        pkt = '{default: 8'h00};
        pkt[0] = OP_LOAD;
        pkt[4] = {6'h0, rt, 1'b1};
        go();
        chk(seek, 0);
        idle();
        chk(seek, 1);
        chk(nrdy, 0);
        chk(ops.size(), rt ? 2 : 1);
        chk(ops[ops.size()-1], MOP_REWIND);
        chk(lp, 0);
        rdr(OFF_STATUS);
        chk(word[15:8], 0);
        rdr(OFF_POSITION);
        chk(word, 0);
    endtask : s_load

    task automatic s_locate(logic [31:0] b, logic [7:0] p);
        ops = {};
        pkt = '{default: 8'h00};
        pkt[0] = OP_LOCATE;
        pkt[1] = 8'h02;
        {pkt[3], pkt[4], pkt[5], pkt[6]} = b;
        pkt[8] = p;
        go();
        chk(seek, 0);
        idle();
        chk(seek, 1);
        chk(ops[0], MOP_PARTITION);
        chk(ops[1], b ? MOP_LOCATE : MOP_TO_START);
        chk(lra, b != 0);
        chk(lp, p);
        if (b)
            chk(lb, b);
        rdr(OFF_STATUS);
        chk(word[15:8], p);
        rdr(OFF_POSITION);
        chk(word, b);
    endtask : s_locate

    task automatic s_unload;
        ops = {};
        pkt = '{default: 8'h00};
        pkt[0] = OP_LOAD;
        pkt[4] = 8'h06;
        go();
        idle();
        chk({ops[0], ops[1]}, {MOP_RETENSION, MOP_TO_END});
        chk(nrdy, 1);
        ops = {};
        pkt[0] = OP_LOCATE;
        go();
        idle();
        chk(ops.size(), 0);
        chk(word[4], 1);
        @(posedge core_clk) cart <= 0;
        pkt[0] = OP_LOAD;
        pkt[4] = 8'h01;
        go();
        idle();
        chk(word[4], 1);
        chk(word[3], 0);
        chk(ops.size(), 0);
        @(posedge core_clk) cart <= 1;
        @(posedge core_clk) mload <= 1;
        @(posedge core_clk) mload <= 0;
        for (i = 0; i < 200 && nrdy !== 1'b0; i++)
            @(posedge core_clk);
        chk(nrdy, 0);
        idle();
    endtask : s_unload

    // f shifts the body when a parameter pointer skips leading parameters
    task automatic s_sense(logic [5:0] pg, logic [15:0] ptr, logic [15:0] al, int n, int f);
        pkt = '{default: 8'h00};
        pkt[0] = OP_LOG_SENSE;
        pkt[2] = {2'b01, pg};
        {pkt[5], pkt[6], pkt[7], pkt[8]} = {ptr, al};
        go();
        rdr(OFF_COUNT);
        chk(word, n);
        for (int k = 0; k < n; k++) begin
            rdr(OFF_DATA_OUT);
            chk(word, {23'h0, 1'b1, eb[k < 4 ? k : f + k]});
        end
        rdr(OFF_DATA_OUT);
        chk(word[8], 0);
    endtask : s_sense

    task automatic fill_err(logic z);
        logic [15:0] c [6] = '{16'h0000, 16'h0001, 16'h8020, 16'h8021, 16'h8022, 16'h8023};
        {eb[0], eb[1], eb[2], eb[3]} = 32'h0300_0030;
        for (int p = 0; p < 6; p++)
            {eb[4+8*p], eb[5+8*p], eb[6+8*p], eb[7+8*p], eb[8+8*p], eb[9+8*p],
             eb[10+8*p], eb[11+8*p]} = {c[p], 8'h40, 8'h04, z ? 32'h0 : 32'(6 - p)};
    endtask : fill_err

    task automatic s_log;
        {eb[0], eb[1], eb[2], eb[3], eb[4], eb[5], eb[6], eb[7]} = 64'h0000_0004_0003_3100;
        s_sense(PAGE_SUPPORTED, 16'h0, 16'h8, 8, 0);
        s_sense(PAGE_SUPPORTED, 16'h0, 16'h5, 5, 0);
        for (int k = 0; k < 6; k++) begin
            @(posedge core_clk) inc <= 6'h3f >> k;
            @(posedge core_clk) inc <= 6'h00;
        end
        fill_err(0);
        s_sense(PAGE_READ_ERR, 16'h0, 16'h3c, 52, 0);
        s_sense(PAGE_READ_ERR, 16'h8022, 16'h3c, 20, 32);
        pkt = '{default: 8'h00};
        {pkt[0], pkt[1], pkt[2], pkt[8]} = 32'h4c02_4002;
        go();
        wrr(OFF_DATA_IN, 32'h0);
        rdr(OFF_STATUS);
        chk(word[2], 1);
        wrr(OFF_DATA_IN, 32'h0);
        idle();
        s_sense(PAGE_READ_ERR, 16'h0, 16'h3c, 52, 0);
        pkt = '{default: 8'h00};
        {pkt[0], pkt[1], pkt[2]} = 24'h4c_0200;
        go();
        rdr(OFF_STATUS);
        chk(word[5], 1);
        pkt[2] = 8'h40;
        go();
        idle();
        fill_err(1);
        s_sense(PAGE_READ_ERR, 16'h0, 16'h3c, 52, 0);
    endtask : s_log

    initial begin
        repeat (20) @(posedge core_clk);
        reset <= 0;
        @(posedge core_clk);
        chk(seek, 1);
        rdr(6'h3c);
        chk(word, 0);
        s_load(0, 6'h01);
        s_load(1, 6'h28);
        s_locate(32'h0001_2345, 8'h01);
        s_locate(32'h0, 8'h01);
        s_load(0, 6'h03);
        s_unload();
        s_log();
        results();
    end
endmodule : tb_tape_position_log_commands
